//--- design/ccp_channel.sv
`timescale 1ns/1ps
module ccp_channel (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sleep,
  input  wire logic [3:0]  mode,
  input  wire logic [1:0]  duty_low_bits,
  input  wire logic [15:0] value,
  input  wire logic [15:0] cc_timer,
  input  wire logic [7:0]  pwm_timer,
  input  wire logic        pwm_period_match,
  input  wire logic        pin_level,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             cap_strobe,
  output logic [15:0]      cap_value,
  output logic             flag_set,
  output logic             special_trig
);
  typedef struct packed {
    logic        pin;
    logic        oe;
    logic        in_prev;
    logic        eq_prev;
    logic [3:0]  presc;
    logic [9:0]  duty_latch;
    logic        cap;
    logic [15:0] cap_val;
    logic        flag;
    logic        special;
  } chan_state_t;

  chan_state_t s_q;
  chan_state_t s_d;
  logic        rising;
  logic        falling;
  logic        eq_now;
  logic        match;
  logic        is_pwm;
  logic        edge_hit;
  logic [3:0]  presc_last;

  assign is_pwm  = (mode[3:2] == ccp_pkg::MODE_PWM_TOP);
  assign rising  = pin_level & ~s_q.in_prev;
  assign falling = ~pin_level & s_q.in_prev;
  assign eq_now  = (cc_timer == value);
  assign match   = eq_now & ~s_q.eq_prev;

  always_comb begin
    s_d = s_q;
    s_d.cap = 1'b0;
    s_d.flag = 1'b0;
    s_d.special = 1'b0;
    edge_hit = 1'b0;
    presc_last = ccp_pkg::PRESCALE4_LAST;
    if (sleep) begin
      // frozen: pin keeps its level and no state advances
      s_d = s_q;
      s_d.cap = 1'b0;
      s_d.flag = 1'b0;
      s_d.special = 1'b0;
    end else if (mode == ccp_pkg::MODE_OFF) begin
      s_d = '0;
    end else begin
      s_d.in_prev = pin_level;
      s_d.eq_prev = eq_now;
      if (is_pwm) begin
        s_d.oe = 1'b1;
        if (pwm_period_match) begin
          s_d.duty_latch = {value[7:0], duty_low_bits};
          s_d.pin = ({value[7:0], duty_low_bits} != '0);
        end else if ({pwm_timer, 2'b00} >= s_q.duty_latch) begin
          s_d.pin = 1'b0;
        end
      end else begin
        // duty_low_bits not read outside PWM
        unique case (mode)
          ccp_pkg::MODE_CAP_FALL: begin
            s_d.oe = 1'b0;
            edge_hit = falling;
            if (edge_hit) begin
              s_d.cap = 1'b1;
            end
          end
          ccp_pkg::MODE_CAP_RISE: begin
            s_d.oe = 1'b0;
            edge_hit = rising;
            if (edge_hit) begin
              s_d.cap = 1'b1;
            end
          end
          ccp_pkg::MODE_CAP_RISE4, ccp_pkg::MODE_CAP_RISE16: begin
            s_d.oe = 1'b0;
            edge_hit = rising;
            presc_last = (mode == ccp_pkg::MODE_CAP_RISE16) ?
                         ccp_pkg::PRESCALE16_LAST : ccp_pkg::PRESCALE4_LAST;
            if (edge_hit) begin
              if (s_q.presc >= presc_last) begin
                s_d.presc = '0;
                s_d.cap = 1'b1;
              end else begin
                s_d.presc = s_q.presc + 4'h1;
              end
            end
          end
          ccp_pkg::MODE_TOGGLE: begin
            s_d.oe = 1'b1;
            if (match) begin
              s_d.pin = ~s_q.pin;
              s_d.flag = 1'b1;
            end
          end
          ccp_pkg::MODE_CMP_SET: begin
            s_d.oe = 1'b1;
            if (match) begin
              s_d.pin = 1'b1;
              s_d.flag = 1'b1;
            end
          end
          ccp_pkg::MODE_CMP_CLR: begin
            s_d.oe = 1'b1;
            if (match) begin
              s_d.pin = 1'b0;
              s_d.flag = 1'b1;
            end
          end
          ccp_pkg::MODE_CMP_SOFT: begin
            if (match) begin
              s_d.flag = 1'b1;
            end
          end
          ccp_pkg::MODE_CMP_SPECIAL: begin
            if (match) begin
              s_d.special = 1'b1;
            end
          end
          default: begin
            s_d.oe = 1'b0;
          end
        endcase
        if (s_d.cap) begin
          s_d.cap_val = cc_timer;
          s_d.flag = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out      = s_q.pin;
  assign pin_oe       = s_q.oe;
  assign cap_strobe   = s_q.cap;
  assign cap_value    = s_q.cap_val;
  assign flag_set     = s_q.flag;
  assign special_trig = s_q.special;

  a_off_resets: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_OFF && !sleep) |=> (!pin_out && !pin_oe && !cap_strobe))
    else $error("channel not held in reset while off");
  a_toggle_match: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_TOGGLE && match && !sleep) |=> (pin_out != $past(pin_out)))
    else $error("toggle mode did not invert pin");
  a_set_match: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_CMP_SET && match && !sleep) |=> (pin_out && flag_set))
    else $error("set mode did not drive high with flag");
  a_clear_match: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_CMP_CLR && match && !sleep) |=> (!pin_out && flag_set))
    else $error("clear mode did not drive low with flag");
  a_soft_match: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_CMP_SOFT && match && !sleep) |=> ($stable(pin_out) && flag_set))
    else $error("software compare changed pin or missed flag");
  a_special_match: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_CMP_SPECIAL && match && !sleep) |=> special_trig)
    else $error("special event not raised");
  a_sleep_holds: assert property (@(posedge core_clk) disable iff (rst)
    sleep |=> ($stable(pin_out) && $stable(pin_oe) && !cap_strobe && !flag_set))
    else $error("channel changed during sleep");
  a_rise_capture: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_CAP_RISE && rising && !sleep) |=>
    (cap_strobe && cap_value == $past(cc_timer)))
    else $error("rising edge not captured");
  a_pwm_duty: assert property (@(posedge core_clk) disable iff (rst)
    (is_pwm && pwm_period_match && !sleep) |=>
    (s_q.duty_latch == {$past(value[7:0]), $past(duty_low_bits)}))
    else $error("pwm duty not built from both fields");
  a_div4_capture: assert property (@(posedge core_clk) disable iff (rst)
    (mode == ccp_pkg::MODE_CAP_RISE4 && rising && !sleep &&
     s_q.presc < ccp_pkg::PRESCALE4_LAST) |=> !cap_strobe)
    else $error("divide-by-four capture fired early");
endmodule // ccp_channel

//--- design/ccp_ctrl_top.sv
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ccp_ctrl_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] t1_count,
  input  wire logic [15:0] t3_count,
  input  wire logic [15:0] t5_count,
  input  wire logic [7:0]  t2_count,
  input  wire logic [7:0]  t4_count,
  input  wire logic [7:0]  t6_count,
  input  wire logic [7:0]  t8_count,
  input  wire logic [7:0]  t10_count,
  input  wire logic        t2_period_match,
  input  wire logic        t4_period_match,
  input  wire logic        t6_period_match,
  input  wire logic        t8_period_match,
  input  wire logic        t10_period_match,
  input  wire logic [9:0]  ccp_pin_in,
  input  wire logic        sleep,
  input  wire logic        adc_enable,
  output logic [9:0]       ccp_pin_out,
  output logic [9:0]       ccp_pin_oe,
  output logic [9:0]       channel_interrupt_flag,
  output logic             adc_trigger,
  output logic             timer_freeze
);
  localparam int N = ccp_pkg::NUM_CH;

  typedef struct packed {
    logic [N-1:0][ccp_pkg::CTRL_W-1:0] ctrl;
    logic [N-1:0][15:0]                value;
    logic [7:0]                        sel0;
    logic [7:0]                        sel1;
    logic [ccp_pkg::SEL2_W-1:0]        sel2;
    logic [N-1:0]                      flags;
    logic                              adc_start;
    logic                              freeze;
    logic                              awready;
    logic                              aw_full;
    ccp_pkg::addr_t                    aw_addr;
    logic                              wready;
    logic                              w_full;
    logic [31:0]                       w_data;
    logic [3:0]                        w_strb;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              arready;
    logic                              rvalid;
    logic [31:0]                       rdata;
    logic [1:0]                        rresp;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic [N-1:0]           pin_sync;
  logic [N-1:0]           cap_strobe;
  logic [N-1:0][15:0]     cap_value;
  logic [N-1:0]           flag_set;
  logic [N-1:0]           special_trig;
  logic [N-1:0]           pin_out;
  logic [N-1:0]           pin_oe;
  logic [N-1:0][15:0]     cc_timer;
  logic [N-1:0][7:0]      pwm_timer;
  logic [N-1:0]           pwm_match;
  logic [ccp_pkg::SEL_ALL_W-1:0] sel_all;

  level_sync #(
    .WIDTH (N)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (ccp_pin_in),
    .sync_out (pin_sync)
  );

  // channel i's select sits at bits 2i+1:2i of the joined registers
  assign sel_all = {s_q.sel2, s_q.sel1, s_q.sel0};

  for (genvar i = 0; i < N; i++) begin : g_ch
    localparam int GRP = (i <= ccp_pkg::GROUP0_LAST) ? 0 :
                         (i <= ccp_pkg::GROUP1_LAST) ? 1 : 2;
    logic [1:0] sel;
    logic [15:0] cc_alt;
    logic [7:0]  tb_cnt;
    logic [7:0]  tc_cnt;
    logic        tb_match;
    logic        tc_match;
    assign sel      = sel_all[ccp_pkg::SEL_W*i +: ccp_pkg::SEL_W];
    assign cc_alt   = (GRP == 0) ? t3_count : t5_count;
    assign tb_cnt   = (GRP == 0) ? t4_count : (GRP == 1) ? t6_count : t8_count;
    assign tc_cnt   = (GRP == 0) ? t6_count : (GRP == 1) ? t8_count : t10_count;
    assign tb_match = (GRP == 0) ? t4_period_match :
                      (GRP == 1) ? t6_period_match : t8_period_match;
    assign tc_match = (GRP == 0) ? t6_period_match :
                      (GRP == 1) ? t8_period_match : t10_period_match;
    assign cc_timer[i] = sel[0] ? cc_alt : t1_count;

    always_comb begin
      unique case (sel)
        ccp_pkg::PWM_SEL_A: begin
          pwm_timer[i] = t2_count;
          pwm_match[i] = t2_period_match;
        end
        ccp_pkg::PWM_SEL_B: begin
          pwm_timer[i] = tb_cnt;
          pwm_match[i] = tb_match;
        end
        ccp_pkg::PWM_SEL_C: begin
          pwm_timer[i] = tc_cnt;
          pwm_match[i] = tc_match;
        end
        default: begin
          pwm_timer[i] = '0;
          pwm_match[i] = 1'b0;
        end
      endcase
    end

    ccp_channel u_ch (
      .core_clk         (core_clk),
      .rst              (rst),
      .sleep            (sleep),
      .mode             (s_q.ctrl[i][ccp_pkg::CTRL_MODE_MSB:ccp_pkg::CTRL_MODE_LSB]),
      .duty_low_bits    (s_q.ctrl[i][ccp_pkg::CTRL_DUTY_MSB:ccp_pkg::CTRL_DUTY_LSB]),
      .value            (s_q.value[i]),
      .cc_timer         (cc_timer[i]),
      .pwm_timer        (pwm_timer[i]),
      .pwm_period_match (pwm_match[i]),
      .pin_level        (pin_sync[i]),
      .pin_out          (pin_out[i]),
      .pin_oe           (pin_oe[i]),
      .cap_strobe       (cap_strobe[i]),
      .cap_value        (cap_value[i]),
      .flag_set         (flag_set[i]),
      .special_trig     (special_trig[i])
    );
  end

  always_comb begin
    logic         wr_hit;
    logic         rd_hit;
    logic [N-1:0] clr;
    logic [N-1:0] set;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    clr = '0;
    set = flag_set;
    s_d = s_q;
    s_d.freeze = sleep;
    s_d.adc_start = (|special_trig) & adc_enable;
    set[ccp_pkg::SPECIAL_CH] = flag_set[ccp_pkg::SPECIAL_CH] | (|special_trig);
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      for (int i = 0; i < N; i++) begin
        if (s_q.aw_addr == ccp_pkg::addr_t'(ccp_pkg::CH_CTRL_BASE + i * ccp_pkg::CH_STRIDE)) begin
          wr_hit = 1'b1;
          if (s_q.w_strb[0]) begin
            s_d.ctrl[i] = s_q.w_data[ccp_pkg::CTRL_W-1:0];
          end
        end
        if (s_q.aw_addr == ccp_pkg::addr_t'(ccp_pkg::CH_VALUE_BASE + i * ccp_pkg::CH_STRIDE)) begin
          wr_hit = 1'b1;
          if (s_q.w_strb[0]) begin
            s_d.value[i][7:0] = s_q.w_data[7:0];
          end
          if (s_q.w_strb[1]) begin
            s_d.value[i][15:8] = s_q.w_data[15:8];
          end
        end
      end
      if (s_q.aw_addr == ccp_pkg::SEL0_OFFSET) begin
        wr_hit = 1'b1;
        if (s_q.w_strb[0]) begin
          s_d.sel0 = s_q.w_data[7:0];
        end
      end
      if (s_q.aw_addr == ccp_pkg::SEL1_OFFSET) begin
        wr_hit = 1'b1;
        if (s_q.w_strb[0]) begin
          s_d.sel1 = s_q.w_data[7:0];
        end
      end
      if (s_q.aw_addr == ccp_pkg::SEL2_OFFSET) begin
        wr_hit = 1'b1;
        if (s_q.w_strb[0]) begin
          s_d.sel2 = s_q.w_data[ccp_pkg::SEL2_W-1:0];
        end
      end
      if (s_q.aw_addr == ccp_pkg::FLAGS_OFFSET) begin
        wr_hit = 1'b1;
        if (s_q.w_strb[0]) begin
          clr[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1]) begin
          clr[N-1:8] = s_q.w_data[N-1:8];
        end
      end
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
    end
    // hardware set wins over a software clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | set;
    for (int i = 0; i < N; i++) begin
      if (cap_strobe[i]) begin
        s_d.value[i] = cap_value[i];
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rdata = '0;
      for (int i = 0; i < N; i++) begin
        if (s_axi_araddr == ccp_pkg::addr_t'(ccp_pkg::CH_CTRL_BASE + i * ccp_pkg::CH_STRIDE)) begin
          rd_hit = 1'b1;
          s_d.rdata[ccp_pkg::CTRL_W-1:0] = s_q.ctrl[i];
        end
        if (s_axi_araddr == ccp_pkg::addr_t'(ccp_pkg::CH_VALUE_BASE + i * ccp_pkg::CH_STRIDE)) begin
          rd_hit = 1'b1;
          s_d.rdata[15:0] = s_q.value[i];
        end
      end
      if (s_axi_araddr == ccp_pkg::SEL0_OFFSET) begin
        rd_hit = 1'b1;
        s_d.rdata[7:0] = s_q.sel0;
      end
      if (s_axi_araddr == ccp_pkg::SEL1_OFFSET) begin
        rd_hit = 1'b1;
        s_d.rdata[7:0] = s_q.sel1;
      end
      if (s_axi_araddr == ccp_pkg::SEL2_OFFSET) begin
        rd_hit = 1'b1;
        s_d.rdata[ccp_pkg::SEL2_W-1:0] = s_q.sel2;
      end
      if (s_axi_araddr == ccp_pkg::FLAGS_OFFSET) begin
        rd_hit = 1'b1;
        s_d.rdata[N-1:0] = s_q.flags;
      end
      s_d.rvalid = 1'b1;
      s_d.rresp = rd_hit ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
    end
    s_d.awready = !s_d.aw_full;
    s_d.wready = !s_d.w_full;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign ccp_pin_out   = pin_out;
  assign ccp_pin_oe    = pin_oe;
  assign channel_interrupt_flag = s_q.flags;
  assign adc_trigger   = s_q.adc_start;
  assign timer_freeze  = s_q.freeze;

  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (rst)
    (special_trig != '0) |=> channel_interrupt_flag[ccp_pkg::SPECIAL_CH])
    else $error("special event lost channel ten flag");
endmodule // ccp_ctrl_top

//--- design/ccp_pkg.sv
package ccp_pkg;
  localparam int NUM_CH  = 10;
  localparam int ADDR_W  = 12;
  localparam int GROUP0_LAST = 3;
  localparam int GROUP1_LAST = 6;
  localparam int SPECIAL_CH  = 9;
  localparam int SEL_W   = 2;
  localparam int SEL_ALL_W = 20;

  typedef logic [ADDR_W-1:0] addr_t;

  // register byte addresses
  localparam addr_t CH_CTRL_BASE  = 12'h000;
  localparam addr_t CH_VALUE_BASE = 12'h004;
  localparam addr_t CH_STRIDE     = 12'h010;
  localparam addr_t SEL0_OFFSET   = 12'h100;
  localparam addr_t SEL1_OFFSET   = 12'h104;
  localparam addr_t SEL2_OFFSET   = 12'h108;
  localparam addr_t FLAGS_OFFSET  = 12'h10C;

  // channel_control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_DUTY_MSB = 5;
  localparam int CTRL_W        = 6;
  localparam int SEL2_W        = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

  // channel_mode_select codes
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_TOGGLE    = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET   = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT  = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP   = 2'h3;

  // channel_timer_select codes in PWM
  localparam logic [1:0] PWM_SEL_A = 2'h0;
  localparam logic [1:0] PWM_SEL_B = 2'h1;
  localparam logic [1:0] PWM_SEL_C = 2'h2;

  localparam logic [3:0] PRESCALE4_LAST  = 4'h3;
  localparam logic [3:0] PRESCALE16_LAST = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 10
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // a change is accepted only once the second and third stages agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.level[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.level;
endmodule // level_sync

//--- sim/ccp_mode_and_timer_select_test.sv
`timescale 1ns/1ps
module ccp_mode_and_timer_select_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0]  ccp_pin_in = 10'h000;
  logic        sleep = 1'b0;
  logic        adc_enable = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [9:0]  ccp_pin_out, ccp_pin_oe, channel_interrupt_flag;
  logic        adc_trigger, timer_freeze, pm;
  logic        trig_seen = 1'b0;
  logic [15:0] t16;
  logic [7:0]  t8;
  int          failures = 0;
  int          n_tests = 0;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (adc_trigger === 1'b1) trig_seen <= 1'b1;

  timer_model timer_model_inst (.core_clk, .rst, .timer_freeze, .t16_count(t16),
    .t8_count(t8), .period_match(pm));
  ccp_ctrl_top ccp_ctrl_top_inst (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .t1_count(t16),
    .t3_count(t16 + 16'h8000),
    .t5_count(t16), .t2_count(t8), .t4_count(t8), .t6_count(t8), .t8_count(t8),
    .t10_count(t8), .t2_period_match(pm), .t4_period_match(pm), .t6_period_match(pm),
    .t8_period_match(pm), .t10_period_match(pm), .ccp_pin_in, .sleep, .adc_enable,
    .ccp_pin_out, .ccp_pin_oe, .channel_interrupt_flag, .adc_trigger, .timer_freeze);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end while (s_axi_bvalid !== 1'b1);
    @(posedge core_clk);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    axi_wr(a, d, rsp);
    axi_rd(a, rd, rsp);
    check("register", exp, rd);
  endtask

  task automatic test_regs;
    logic [11:0] regs [5] = '{12'h000, 12'h090, 12'h100, 12'h104, 12'h108};
    foreach (regs[i]) begin
      axi_rd(regs[i], rd, rsp);
      check("reset value", 32'h0, rd);
    end
    wr_rd(12'h030, 32'hFF, 32'h3F);
    wr_rd(12'h108, 32'hFF, 32'h0F);
    wr_rd(12'h100, 32'hA5, 32'hA5);
    wr_rd(12'h104, 32'h5A, 32'h5A);
    axi_rd(12'h200, rd, rsp);
    check("unmapped resp", {30'h0, ccp_pkg::RESP_SLVERR}, {30'h0, rsp});
    check("unmapped data", 32'h0, rd);
    axi_wr(12'h100, 32'h0, rsp);
    $display("done registers");
  endtask

  task automatic test_compare;
    logic [3:0]  modes [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
    logic        pins [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [15:0] v;
    for (int i = 0; i < 5; i++) begin
      axi_wr(12'h10C, 32'h3FF, rsp);
      axi_wr(12'h000, {28'h0, modes[i]}, rsp);
      v = t16 + 16'h0020;
      axi_wr(12'h004, {16'h0, v}, rsp);
      while (t16 !== v + 16'h0008) @(posedge core_clk);
      check("pin", {31'h0, pins[i]}, {31'h0, ccp_pin_out[0]});
      axi_rd(12'h10C, rd, rsp);
      check("flags", (i == 4) ? 32'h200 : 32'h001, rd);
    end
    check("adc trigger", 32'h1, {31'h0, trig_seen});
    $display("done compare");
  endtask

  task automatic test_capture;
    axi_wr(12'h10C, 32'h3FF, rsp);
    axi_wr(12'h010, 32'h35, rsp);
    ccp_pin_in[1] <= 1'b1;
    repeat (10) @(posedge core_clk);
    axi_rd(12'h10C, rd, rsp);
    check("rise capture", 32'h002, rd);
    axi_wr(12'h10C, 32'h3FF, rsp);
    axi_wr(12'h010, 32'h04, rsp);
    ccp_pin_in[1] <= 1'b0;
    repeat (10) @(posedge core_clk);
    axi_rd(12'h10C, rd, rsp);
    check("fall capture", 32'h002, rd);
    axi_wr(12'h000, 32'h0, rsp);
    check("off pin", 32'h0, {30'h0, ccp_pin_oe[0], ccp_pin_out[0]});
    $display("done capture and off");
  endtask

  task automatic test_prescale;
    axi_wr(12'h10C, 32'h3FF, rsp);
    axi_wr(12'h020, 32'h06, rsp);
    for (int i = 1; i <= 4; i++) begin
      ccp_pin_in[2] <= 1'b1;
      repeat (8) @(posedge core_clk);
      ccp_pin_in[2] <= 1'b0;
      repeat (8) @(posedge core_clk);
      check("div4 flag", {31'h0, i == 4}, {31'h0, channel_interrupt_flag[2]});
    end
    $display("done prescale");
  endtask

  task automatic test_select;
    axi_wr(12'h100, 32'h01, rsp);
    axi_wr(12'h000, 32'h08, rsp);
    axi_wr(12'h004, {16'h0, t16 + 16'h0020}, rsp);
    repeat (40) @(posedge core_clk);
    check("timer1 ignored", 32'h0, {31'h0, ccp_pin_out[0]});
    axi_wr(12'h004, {16'h0, t16 + 16'h8020}, rsp);
    repeat (40) @(posedge core_clk);
    check("timer3 used", 32'h1, {31'h0, ccp_pin_out[0]});
    $display("done select");
  endtask

  task automatic test_sleep;
    axi_wr(12'h000, 32'h02, rsp);
    axi_wr(12'h004, {16'h0, t16 + 16'h8010}, rsp);
    sleep <= 1'b1;
    repeat (40) @(posedge core_clk);
    check("sleep hold", 32'h3, {30'h0, timer_freeze, ccp_pin_out[0]});
    sleep <= 1'b0;
    repeat (40) @(posedge core_clk);
    check("wake toggle", 32'h0, {30'h0, timer_freeze, ccp_pin_out[0]});
    $display("done sleep");
  endtask

  task automatic test_pwm;
    axi_wr(12'h034, 32'h80, rsp);
    while (pm !== 1'b1) @(posedge core_clk);
    while (t8 !== 8'h40) @(posedge core_clk);
    check("pwm high", 32'h3, {30'h0, ccp_pin_oe[3], ccp_pin_out[3]});
    while (t8 !== 8'hC0) @(posedge core_clk);
    check("pwm low", 32'h2, {30'h0, ccp_pin_oe[3], ccp_pin_out[3]});
    $display("done pwm");
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    test_regs;
    test_compare;
    test_capture;
    test_prescale;
    test_select;
    test_sleep;
    test_pwm;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test;
  end
endmodule // ccp_mode_and_timer_select_test

//--- sim/timer_model.sv
`timescale 1ns/1ps
module timer_model (
  input  wire logic   core_clk,
  input  wire logic   rst,
  input  wire logic   timer_freeze,
  output logic [15:0] t16_count,
  output logic [7:0]  t8_count,
  output logic        period_match
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t16_count <= 16'h0000;
      t8_count  <= 8'h00;
    end else if (!timer_freeze) begin
      t16_count <= t16_count + 16'h0001;
      t8_count  <= t8_count + 8'h01;
    end
  end
  assign period_match = (t8_count == 8'hFF) && !timer_freeze;
endmodule // timer_model
